// ### irq_route_pkg.sv
/*
  Shared constants and carriers for the interrupt pin and route block:
  window offsets, field positions, reset values and the register access structs.
  Assumes offsets are relative to the root complex base window, 14 bits wide.
*/
package irq_route_pkg;

  localparam int NUM_PIN_SEL = 7;
  localparam int NUM_ROUTE   = 8;
  localparam int NUM_LINE    = 8;
  localparam int NUM_PIN     = 4;
  localparam int ADDR_W      = 14;

  // Pin-select order: audio, root ports d26, d25, d24, d23, graphics, display
  localparam logic [NUM_PIN_SEL-1:0][ADDR_W-1:0] PIN_SEL_OFS = {
    14'h3130, 14'h3118, 14'h312C, 14'h3128, 14'h3124, 14'h3120, 14'h3110
  };

  // Route order: dev 31, 27, 26, 25, 24, 23, 2, 3
  localparam logic [NUM_ROUTE-1:0][ADDR_W-1:0] ROUTE_OFS = {
    14'h3162, 14'h3160, 14'h3150, 14'h314E, 14'h314C, 14'h314A, 14'h3148, 14'h3140
  };

  localparam int PIN_FIELD_LSB = 0;
  localparam int PIN_FIELD_W   = 4;
  localparam int ROUTE_A_LSB   = 0;
  localparam int ROUTE_B_LSB   = 4;
  localparam int ROUTE_C_LSB   = 8;
  localparam int ROUTE_D_LSB   = 12;
  localparam int ROUTE_W       = 16;

  localparam logic [3:0]  PIN_SEL_RESET = 4'h1;
  localparam logic [3:0]  PIN_NONE      = 4'h0;
  localparam logic [3:0]  PIN_LAST      = 4'h4;
  localparam logic [3:0]  LINE_LAST     = 4'h7;
  localparam logic [15:0] ROUTE_RESET   = 16'h3210;

  typedef struct packed {
    logic              valid;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [3:0]        byte_en;
    logic [31:0]       wdata;
  } reg_req_s;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } reg_rsp_s;

endpackage : irq_route_pkg

// ### pin_steer.sv
/*
  Steers one function's interrupt request onto the legacy pin A..D it selects.
  Assumes the request is a level synchronous to the block clock.
*/
`timescale 1ns/10ps
module pin_steer
  import irq_route_pkg::*;
(
  input  wire logic                 irq_i,
  input  wire logic [3:0]           pin_sel_i,
  output logic      [NUM_PIN-1:0]   pins_o
);

  always_comb begin
    pins_o = '0;
    // Zero and reserved codes leave the request unconnected
    if (pin_sel_i != PIN_NONE && pin_sel_i <= PIN_LAST) begin // [R4] [R12]
      pins_o[pin_sel_i[1:0] - 2'h1] = irq_i;
    end
  end

endmodule : pin_steer

// ### line_router.sv
/*
  Maps one device's four legacy pins onto the eight internal interrupt lines.
  Assumes route fields laid out D, C, B, A from the top nibble down.
*/
`timescale 1ns/10ps
module line_router
  import irq_route_pkg::*;
(
  input  wire logic [NUM_PIN-1:0]  pins_i,
  input  wire logic [ROUTE_W-1:0]  route_i,
  output logic      [NUM_LINE-1:0] lines_o
);

  always_comb begin
    logic [3:0] fld;
    fld     = '0;
    lines_o = '0;
    for (int p = 0; p < NUM_PIN; p++) begin
      fld = route_i[p*4 +: 4];
      // Codes above H are reserved: the pin goes nowhere
      if (fld <= LINE_LAST) begin // [R6] [R12]
        lines_o[fld[2:0]] = lines_o[fld[2:0]] | pins_i[p]; // [R7]
      end
    end
  end

endmodule : line_router

// ### irq_route_cfg.sv
/*
  Interrupt pin-select and route configuration registers with the routing
  datapath that feeds eight internal interrupt lines to the interrupt controller.
  Assumes single 32-bit (or narrower, byte-enabled) accesses from the root
  complex window decoder, one clock, and level interrupt requests.
*/
// How it works
// R1 - The audio pin-select register holds a 4-bit RW field in bits 3:0 resetting to 1h, upper bits read zero.
// R2 - Graphics and display pin-select registers each hold a 4-bit RW field resetting to 1h.
// R3 - Four root-port pin-select registers each hold a 4-bit RW field resetting to 1h.
// R4 - Pin code 0h means no interrupt, 1h-4h pick pins A-D, 5h-Fh are reserved.
// R5 - Each function's pin-select value is reported in its configuration interrupt-pin register.
// R6 - Route codes 0h-7h pick internal lines A-H, 8h-Fh are reserved.
// R7 - Routing is internal: selected pins drive internal lines toward the interrupt controller.
// R8 - Each route register is 16 bits RW with pin D, C, B, A fields resetting to 3h, 2h, 1h, 0h.
// R9 - Separate route registers exist for devices 31, 27, 26, 25, 24, 23, 2 and 3 at 3140h-3162h.
// R10 - All these registers decode as memory locations relative to the root complex base window.
// R11 - Software uses only single 32-bit accesses to the window, never bursts.
// R12 - Reserved upper pin-select bits ignore writes and reserved codes leave the interrupt unconnected.
`timescale 1ns/10ps
module irq_route_cfg
  import irq_route_pkg::*;
(
  input  wire logic                                clk_i,
  input  wire logic                                rst_b_i,
  input  wire reg_req_s                            reg_req_i,
  output reg_rsp_s                                 reg_rsp_o,
  input  wire logic      [NUM_PIN-1:0]             dev31_pins_i,
  input  wire logic      [NUM_PIN_SEL-1:0]         func_irq_i,
  output logic           [NUM_PIN_SEL-1:0][3:0]    config_interrupt_pin_reg_o,
  output logic           [NUM_LINE-1:0]            internal_irq_line_o
);

  logic                                 rst_meta_r;
  logic                                 rst_b_r;
  logic [NUM_PIN_SEL-1:0][3:0]          pin_sel_r;
  logic [NUM_PIN_SEL-1:0][3:0]          pin_sel_nxt;
  logic [NUM_ROUTE-1:0][ROUTE_W-1:0]    route_r;
  logic [NUM_ROUTE-1:0][ROUTE_W-1:0]    route_nxt;
  logic                                 ack_r;
  logic                                 ack_nxt;
  logic [31:0]                          rdata_r;
  logic [31:0]                          rdata_nxt;
  logic [NUM_LINE-1:0]                  line_r;
  logic [NUM_LINE-1:0]                  line_nxt;
  logic [NUM_ROUTE-1:0][NUM_PIN-1:0]    dev_pins;
  logic [NUM_ROUTE-1:0][NUM_LINE-1:0]   dev_lines;
  logic                                 wr_en;
  logic                                 rd_en;
  logic [ADDR_W-3:0]                    dw_addr;

  // Reset release through two flops; assertion is still immediate
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta_r <= 1'b0;
      rst_b_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_b_r    <= rst_meta_r;
    end
  end

  assign wr_en   = reg_req_i.valid & reg_req_i.write;
  assign rd_en   = reg_req_i.valid & ~reg_req_i.write;
  assign dw_addr = reg_req_i.addr[ADDR_W-1:2];

  // Register writes; three dwords each hold two 16-bit route registers
  always_comb begin
    pin_sel_nxt = pin_sel_r;
    route_nxt   = route_r;
    if (wr_en) begin
      for (int i = 0; i < NUM_PIN_SEL; i++) begin
        // Only lane 0 carries the field; bits 31:4 have no storage
        if (dw_addr == PIN_SEL_OFS[i][ADDR_W-1:2] && reg_req_i.byte_en[0]) begin // [R10] [R12]
          pin_sel_nxt[i] = reg_req_i.wdata[PIN_FIELD_LSB +: PIN_FIELD_W]; // [R1] [R2] [R3]
        end
      end
      for (int j = 0; j < NUM_ROUTE; j++) begin
        if (dw_addr == ROUTE_OFS[j][ADDR_W-1:2]) begin // [R9] [R10]
          if (ROUTE_OFS[j][1]) begin
            if (reg_req_i.byte_en[2]) route_nxt[j][7:0]  = reg_req_i.wdata[23:16]; // [R8]
            if (reg_req_i.byte_en[3]) route_nxt[j][15:8] = reg_req_i.wdata[31:24]; // [R8]
          end else begin
            if (reg_req_i.byte_en[0]) route_nxt[j][7:0]  = reg_req_i.wdata[7:0]; // [R8]
            if (reg_req_i.byte_en[1]) route_nxt[j][15:8] = reg_req_i.wdata[15:8]; // [R8]
          end
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_r) begin
    if (!rst_b_r) begin
      pin_sel_r <= {NUM_PIN_SEL{PIN_SEL_RESET}}; // [R1] [R2] [R3]
      route_r   <= {NUM_ROUTE{ROUTE_RESET}}; // [R8]
    end else begin
      pin_sel_r <= pin_sel_nxt;
      route_r   <= route_nxt;
    end
  end

  // Read path; unmapped dwords and reserved bits return zero
  always_comb begin
    rdata_nxt = '0;
    ack_nxt   = reg_req_i.valid;
    if (rd_en) begin
      for (int i = 0; i < NUM_PIN_SEL; i++) begin
        if (dw_addr == PIN_SEL_OFS[i][ADDR_W-1:2]) begin
          rdata_nxt = rdata_nxt | {28'h0000000, pin_sel_r[i]}; // [R1] [R12]
        end
      end
      for (int j = 0; j < NUM_ROUTE; j++) begin
        if (dw_addr == ROUTE_OFS[j][ADDR_W-1:2]) begin
          if (ROUTE_OFS[j][1]) begin
            rdata_nxt = rdata_nxt | {route_r[j], 16'h0000}; // [R9]
          end else begin
            rdata_nxt = rdata_nxt | {16'h0000, route_r[j]}; // [R9]
          end
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_r) begin
    if (!rst_b_r) begin
      ack_r   <= 1'b0;
      rdata_r <= '0;
    end else begin
      ack_r   <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rsp_o.ack   = ack_r;
  assign reg_rsp_o.rdata = rdata_r;

  // Interrupt-pin value seen by each function's config header
  assign config_interrupt_pin_reg_o = pin_sel_r; // [R5]

  // Device 31 arrives already on pins; the rest steer through their pin field
  generate
    for (genvar d = 0; d < NUM_ROUTE; d++) begin : g_dev
      if (d == 0) begin : g_fixed
        assign dev_pins[d] = dev31_pins_i;
      end else begin : g_steer
        pin_steer u_steer (
          .irq_i     (func_irq_i[d-1]),
          .pin_sel_i (pin_sel_r[d-1]),
          .pins_o    (dev_pins[d])
        );
      end
      line_router u_router (
        .pins_i  (dev_pins[d]),
        .route_i (route_r[d]),
        .lines_o (dev_lines[d])
      );
    end
  endgenerate

  // Lines are shared: any device routed to a line asserts it
  always_comb begin
    line_nxt = '0;
    for (int d = 0; d < NUM_ROUTE; d++) begin
      line_nxt = line_nxt | dev_lines[d]; // [R7]
    end
  end

  // Registered to keep the controller input glitch free
  always_ff @(posedge clk_i or negedge rst_b_r) begin
    if (!rst_b_r) begin
      line_r <= '0;
    end else begin
      line_r <= line_nxt;
    end
  end

  assign internal_irq_line_o = line_r;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_r);

  sequence s_pin_write(int idx);
    wr_en && dw_addr == PIN_SEL_OFS[idx][ADDR_W-1:2] && reg_req_i.byte_en[0];
  endsequence

  sequence s_pin_read(int idx);
    rd_en && dw_addr == PIN_SEL_OFS[idx][ADDR_W-1:2];
  endsequence

  property p_pin_rsvd_zero;
    s_pin_read(0) |=> ack_r && rdata_r[31:4] == 28'h0000000;
  endproperty
  a_pin_rsvd_zero: assert property (p_pin_rsvd_zero) // [R1]
    else $error("Reserved pin-select bits read nonzero");

  property p_pin_write_read;
    s_pin_write(5) ##1 s_pin_read(5) |=> rdata_r[3:0] == $past(reg_req_i.wdata[3:0], 2);
  endproperty
  a_pin_write_read: assert property (p_pin_write_read) // [R2]
    else $error("Graphics pin field did not hold written value");

  property p_rp_write_cfg;
    s_pin_write(4) |=> config_interrupt_pin_reg_o[4] == $past(reg_req_i.wdata[3:0]);
  endproperty
  a_rp_write_cfg: assert property (p_rp_write_cfg) // [R3]
    else $error("Root port pin field not updated by write");

  property p_pin_none_quiet;
    pin_sel_r[0] == PIN_NONE && route_r[1] == 16'h3210 && func_irq_i == 7'h01
      && dev31_pins_i == 4'h0 |=> internal_irq_line_o == 8'h00;
  endproperty
  a_pin_none_quiet: assert property (p_pin_none_quiet) // [R4]
    else $error("Function with no pin still raised a line");

  property p_cfg_pin_follows;
    s_pin_write(6) ##1 1'b1 |-> config_interrupt_pin_reg_o[6] == $past(reg_req_i.wdata[3:0]);
  endproperty
  a_cfg_pin_follows: assert property (p_cfg_pin_follows) // [R5]
    else $error("Config interrupt pin does not match display field");

  property p_audio_route;
    pin_sel_r[0] == 4'h1 && route_r[1][3:0] == 4'h3 && func_irq_i[0]
      |=> internal_irq_line_o[3];
  endproperty
  a_audio_route: assert property (p_audio_route) // [R6] [R7]
    else $error("Audio request did not reach line D");

  property p_rsvd_route_open;
    dev31_pins_i == 4'h1 && route_r[0][3:0] == 4'h8 && func_irq_i == 7'h00
      |=> internal_irq_line_o == 8'h00;
  endproperty
  a_rsvd_route_open: assert property (p_rsvd_route_open) // [R12]
    else $error("Reserved route code drove a line");

  property p_half_write;
    wr_en && dw_addr == ROUTE_OFS[2][ADDR_W-1:2] && reg_req_i.byte_en == 4'hC
      |=> route_r[2] == $past(reg_req_i.wdata[31:16]) && route_r[1] == $past(route_r[1]);
  endproperty
  a_half_write: assert property (p_half_write) // [R8] [R9]
    else $error("Upper-half route write disturbed lower register");

  property p_unmapped_zero;
    rd_en && reg_req_i.addr == 14'h3114 |=> ack_r && rdata_r == 32'h00000000;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) // [R10]
    else $error("Unmapped read returned data");

  property p_ack_one;
    reg_req_i.valid |=> ack_r ##1 (ack_r == $past(reg_req_i.valid));
  endproperty
  a_ack_one: assert property (p_ack_one) // [R11]
    else $error("Access answer not one cycle after request");

  property p_write_rdata_zero;
    wr_en |=> ack_r && rdata_r == 32'h00000000;
  endproperty
  a_write_rdata_zero: assert property (p_write_rdata_zero) // [R10]
    else $error("Write answer carried read data");

  property p_idle_no_ack;
    !reg_req_i.valid |=> !ack_r;
  endproperty
  a_idle_no_ack: assert property (p_idle_no_ack) // [R10]
    else $error("Answer given without a request");

  property p_route_read_low;
    rd_en && dw_addr == ROUTE_OFS[0][ADDR_W-1:2]
      |=> ack_r && rdata_r == {16'h0000, $past(route_r[0])};
  endproperty
  a_route_read_low: assert property (p_route_read_low) // [R9]
    else $error("Device 31 route read back wrong");

  property p_route_read_high;
    rd_en && dw_addr == ROUTE_OFS[2][ADDR_W-1:2]
      |=> rdata_r[31:16] == $past(route_r[2]) && rdata_r[15:0] == $past(route_r[1]);
  endproperty
  a_route_read_high: assert property (p_route_read_high) // [R9]
    else $error("Shared route dword read back wrong");

  property p_dev31_line_f;
    route_r[0][3:0] == 4'h5 && dev31_pins_i[0] |=> internal_irq_line_o[5];
  endproperty
  a_dev31_line_f: assert property (p_dev31_line_f) // [R6]
    else $error("Device 31 pin A missed line F");

  property p_pin_d_route;
    route_r[0][15:12] == 4'h3 && dev31_pins_i[3] |=> internal_irq_line_o[3];
  endproperty
  a_pin_d_route: assert property (p_pin_d_route) // [R8]
    else $error("Device 31 pin D missed its routed line");

  property p_lines_quiet;
    func_irq_i == 7'h00 && dev31_pins_i == 4'h0 |=> internal_irq_line_o == 8'h00;
  endproperty
  a_lines_quiet: assert property (p_lines_quiet) // [R7]
    else $error("Line raised with no request pending");

  property p_rsvd_pin_quiet;
    pin_sel_r[0] > PIN_LAST && func_irq_i == 7'h01 && dev31_pins_i == 4'h0
      |=> internal_irq_line_o == 8'h00;
  endproperty
  a_rsvd_pin_quiet: assert property (p_rsvd_pin_quiet) // [R4] [R12]
    else $error("Reserved pin code still raised a line");

endmodule : irq_route_cfg

// ### irq_ctrl_model.sv
/*
  Behavioural stand-in for the interrupt controller fed by the internal lines.
  Assumes active-high level lines sampled on the block clock.
*/
`timescale 1ns/10ps
module irq_ctrl_model
  import irq_route_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                rst_b_i,
  input  wire logic [NUM_LINE-1:0] lines_i,
  output logic      [NUM_LINE-1:0] seen_o
);
  logic [NUM_LINE-1:0] seen_r;
  logic [NUM_LINE-1:0] seen_nxt;

  // Level-sensitive capture, no latching, so a dropped request shows on the next clock
  always_comb begin
    seen_nxt = lines_i;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      seen_r <= '0;
    end else begin
      seen_r <= seen_nxt;
    end
  end

  assign seen_o = seen_r;
endmodule : irq_ctrl_model

// ### tb_top.sv
/*
  Self-checking bench for the interrupt pin-select and route registers.
  Assumes the valid/ack register port and one registered edge on the line path.
*/
`timescale 1ns/10ps
`define CHK(got, exp) \
  begin n_checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("Error at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module tb_top
  import irq_route_pkg::*;
;
  localparam logic [ADDR_W-1:0] RT_ADR [5] = '{14'h3140, 14'h3148, 14'h314C, 14'h3150, 14'h3160};
  localparam logic [31:0]       RT_RST [5] = '{32'h3210, 32'h32103210, 32'h32103210,
                                               32'h3210, 32'h32103210};
  logic                          clk_i = 1'b0;
  logic                          rst_b_i = 1'b0;
  reg_req_s                      req = '0;
  reg_rsp_s                      rsp;
  logic [NUM_PIN-1:0]            d31_pins = '0;
  logic [NUM_PIN_SEL-1:0]        fn_irq = '0;
  logic [NUM_PIN_SEL-1:0][3:0]   pin_cfg;
  logic [NUM_LINE-1:0]           lines;
  logic [NUM_LINE-1:0]           seen;
  int                            n_mismatch = 0;
  int                            n_checks = 0;
  int                            cycles = 0;

  irq_route_cfg i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_req_i(req), .reg_rsp_o(rsp),
    .dev31_pins_i(d31_pins), .func_irq_i(fn_irq), .config_interrupt_pin_reg_o(pin_cfg),
    .internal_irq_line_o(lines));
  irq_ctrl_model i_ctrl (.clk_i(clk_i), .rst_b_i(rst_b_i), .lines_i(lines), .seen_o(seen));

  initial begin
    forever #20 clk_i = ~clk_i;
  end

  task automatic give_verdict;
    if (n_mismatch == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  // Single dword access, valid for one cycle only: no bursts into the window
  task automatic acc(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                     input logic [3:0] be, input logic [31:0] exp);
    @(posedge clk_i);
    req <= '{valid: 1'b1, write: wr, addr: a, byte_en: be, wdata: d};
    @(posedge clk_i);
    req.valid <= 1'b0;
    #1;
    `CHK(rsp.ack, 1'b1)
    if (!wr) `CHK(rsp.rdata, exp)
  endtask : acc

  // Register already written by acc; lines land in c1, controller copy in c2, c3 spare
  task automatic settle;
    repeat (3) @(posedge clk_i);
    #1;
  endtask : settle

  task automatic t_reset;
    for (int i = 0; i < NUM_PIN_SEL; i++) begin
      acc(1'b0, PIN_SEL_OFS[i], 32'h0, 4'h0, 32'h1);
      `CHK(pin_cfg[i], 4'h1)
    end
    for (int i = 0; i < 5; i++) begin
      acc(1'b0, RT_ADR[i], 32'h0, 4'h0, RT_RST[i]);
    end
    acc(1'b0, 14'h3200, 32'h0, 4'h0, 32'h0);
    acc(1'b0, 14'h3114, 32'h0, 4'h0, 32'h0);
  endtask : t_reset

  task automatic t_pin_fields;
    for (int i = 0; i < NUM_PIN_SEL; i++) begin
      acc(1'b1, PIN_SEL_OFS[i], 32'hFFFF_FFF0 | (i + 2), 4'hF, 32'h0);
      acc(1'b0, PIN_SEL_OFS[i], 32'h0, 4'h0, 32'(i + 2));
      `CHK(pin_cfg[i], 4'(i + 2))
    end
  endtask : t_pin_fields

  // Write then read with no idle cycle between: valid stays high
  task automatic t_back_to_back;
    @(posedge clk_i);
    req <= '{valid: 1'b1, write: 1'b1, addr: PIN_SEL_OFS[5], byte_en: 4'h1, wdata: 32'h3};
    @(posedge clk_i);
    req <= '{valid: 1'b1, write: 1'b0, addr: PIN_SEL_OFS[5], byte_en: 4'h0, wdata: 32'h0};
    @(posedge clk_i);
    req.valid <= 1'b0;
    #1;
    `CHK(rsp.ack, 1'b1)
    `CHK(rsp.rdata, 32'h3)
  endtask : t_back_to_back

  // Audio through default dev27 routing, pin codes 0h-5h incl. none and reserved 5h
  task automatic t_steer;
    @(posedge clk_i);
    fn_irq <= 7'h01;
    for (int c = 0; c < 6; c++) begin
      acc(1'b1, PIN_SEL_OFS[0], 32'(c), 4'h1, 32'h0);
      settle();
      `CHK(seen, (c >= 1 && c <= 4) ? 8'(1 << (c - 1)) : 8'h00)
    end
    // Upper lanes only: dev26 changes, dev27 in the low half must not
    acc(1'b1, 14'h3148, 32'h7654_0000, 4'hC, 32'h0);
    acc(1'b0, 14'h3148, 32'h0, 4'h0, 32'h7654_3210);
    acc(1'b1, PIN_SEL_OFS[1], 32'h1, 4'h1, 32'h0);
    @(posedge clk_i);
    fn_irq <= 7'h02;
    settle();
    `CHK(seen, 8'h10)
    // Lower lanes only: audio pin A now goes to line D
    acc(1'b1, 14'h3148, 32'h0000_3213, 4'h3, 32'h0);
    acc(1'b0, 14'h3148, 32'h0, 4'h0, 32'h7654_3213);
    acc(1'b1, PIN_SEL_OFS[0], 32'h1, 4'h1, 32'h0);
    @(posedge clk_i);
    fn_irq <= 7'h01;
    settle();
    `CHK(seen, 8'h08)
    @(posedge clk_i);
    fn_irq <= 7'h00;
  endtask : t_steer

  // Device 31 pin A over every line code, then the reserved one
  task automatic t_route31;
    @(posedge clk_i);
    d31_pins <= 4'h1;
    for (int k = 0; k < 9; k++) begin
      acc(1'b1, 14'h3140, {28'h0000321, 4'(k)}, 4'hF, 32'h0);
      settle();
      `CHK(lines, (k < 8) ? 8'(1 << k) : 8'h00)
    end
    @(posedge clk_i);
    d31_pins <= 4'h8;
    settle();
    `CHK(lines, 8'h08)
  endtask : t_route31

  initial begin
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    t_reset();
    t_pin_fields();
    t_back_to_back();
    t_steer();
    t_route31();
    give_verdict();
  end

  // Whole run needs well under a thousand cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      give_verdict();
    end
  end
endmodule : tb_top
